// ### core/snr_core.sv
// serial nor command interpreter: link shifter and array operation control
`timescale 1ns/1ps
module snr_core
  import snr_pkg::*;
#(
  // identification bytes, byte 0 in the low bits; value is arbitrary
  parameter logic [63:0] ID_VALUE = 64'h0000_0000_0055_AA11,
  // parameter table, byte 0 in the low bits; value is arbitrary
  parameter logic [127:0] DISCOVERABLE_PARAM_TABLE_TABLE =
    128'h0F0E_0D0C_0B0A_0908_0706_0504_FF01_0050
)
(
  // system clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] quad_data_lanes_in,
  output logic [3:0] quad_data_lanes_out,
  output logic [3:0] quad_data_lanes_oe,
  // configuration
  input wire logic quad_command_mode,
  input wire logic quad_enable,
  input wire logic [3:0] read_latency,
  input wire logic block_protect,
  // array read port, link clock
  output logic [ADDR_BITS-1:0] array_rd_addr,
  input wire logic [7:0] array_rd_data,
  // program data stream, link clock
  output logic [7:0] prog_data,
  output logic prog_valid,
  output logic [10:0] prog_index,
  // array operation handshake, system clock
  output logic op_req,
  output snr_op_t op_kind,
  output logic [ADDR_BITS-1:0] op_addr,
  output logic [11:0] op_bytes,
  input wire logic op_done,
  // status
  output logic write_enable_latch,
  output logic continuous_mode,
  output logic soft_reset,
  output logic [63:0] serial_number
);
  // frame-frozen copies in the system domain, read by the link
  logic f_qpi;
  logic f_quad;
  logic [3:0] f_lat;
  logic f_busy;
  logic f_cont;
  // link state, cleared by deselect
  logic fresh;
  snr_phase_t phase;
  logic [4:0] cnt;
  logic [23:0] sh;
  logic [ADDR_BITS-1:0] ptr;
  // link results, kept after deselect
  logic [7:0] opc_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic mode_cont;
  logic [11:0] nbytes;
  logic partial;
  logic [63:0] sn_shift;
  logic done_tog;
  // link combinational
  snr_phase_t eff_phase;
  snr_phase_t next_phase;
  logic [7:0] eff_opc;
  logic [4:0] lim;
  logic [4:0] next_cnt;
  logic [23:0] next_sh;
  logic [ADDR_BITS-1:0] next_ptr;
  logic q_sh;
  logic [7:0] cur_byte;

  assign eff_phase = fresh ? (f_cont ? ph_addr : ph_opc) : phase;
  assign eff_opc = (fresh && f_cont) ? OPC_QIOR : opc_q;
  assign array_rd_addr = ptr;

  // lane widths per phase
  wire q_cmd = f_qpi;
  wire q_addr = f_qpi | (eff_opc == OPC_QIOR);
  wire q_out = f_qpi | (eff_opc inside {OPC_QOR, OPC_QIOR, OPC_QUAD_IDENT_READ_CMD});
  wire q_in = f_qpi | (eff_opc == OPC_QPP);
  wire last = (cnt == lim - 5'd1);
  wire [7:0] new_opc = next_sh[7:0];

  wire fixed_dummy = eff_opc inside {OPC_IDENT_READ_CMD, OPC_QUAD_IDENT_READ_CMD, OPC_PARAM_TABLE_READ_CMD};
  wire [4:0] dum_n = fixed_dummy ? 5'(ID_DUMMY) : {1'b0, f_lat};
  wire after_dummy_skip = (dum_n == 5'd0);

  // opcode decode for the link
  wire op_has_addr = new_opc inside {OPC_READ, OPC_FAST, OPC_QOR, OPC_QIOR,
    OPC_PP, OPC_QPP, OPC_PSCRUB, OPC_SE, OPC_BE, OPC_PARAM_TABLE_READ_CMD};
  wire op_is_id = (new_opc == OPC_IDENT_READ_CMD) |
    ((new_opc == OPC_QUAD_IDENT_READ_CMD) & (f_qpi | f_quad));
  wire id_phase_sel = f_busy ? 1'b1 : 1'b0;

  always_comb
  begin
    unique case (eff_phase)
      ph_opc: lim = q_cmd ? 5'(CMD_EDGES_QUAD) : 5'(CMD_EDGES_SINGLE);
      ph_addr: lim = q_addr ? 5'(ADDR_EDGES_QUAD) : 5'(ADDR_EDGES_SINGLE);
      ph_mode: lim = 5'(MODE_EDGES);
      ph_dummy: lim = dum_n;
      ph_dout: lim = q_out ? 5'(BYTE_EDGES_QUAD) : 5'(BYTE_EDGES_SINGLE);
      ph_din: lim = q_in ? 5'(BYTE_EDGES_QUAD) : 5'(BYTE_EDGES_SINGLE);
      ph_ign: lim = 5'd0;
      default: lim = 5'd0;
    endcase
  end

  always_comb
  begin
    unique case (eff_phase)
      ph_opc: q_sh = q_cmd;
      ph_addr, ph_mode: q_sh = q_addr;
      ph_din: q_sh = q_in;
      ph_dummy, ph_dout, ph_ign: q_sh = 1'b0;
      default: q_sh = 1'b0;
    endcase
  end

  assign next_sh = q_sh ? {sh[19:0], quad_data_lanes_in}
                        : {sh[22:0], quad_data_lanes_in[0]};

  // byte source for output
  // id byte wrap
  wire [7:0] id_byte = ID_VALUE[{ptr[2:0], 3'b000} +: 8];
  wire [7:0] sn_byte = serial_number[{ptr[2:0], 3'b000} +: 8];
  wire [7:0] discoverable_param_table_byte = DISCOVERABLE_PARAM_TABLE_TABLE[{ptr[3:0], 3'b000} +: 8];
  wire is_id = eff_opc inside {OPC_IDENT_READ_CMD, OPC_QUAD_IDENT_READ_CMD};
  assign cur_byte = is_id ? id_byte
                  : (eff_opc == OPC_SERIAL_NUMBER_READ_CMD) ? sn_byte
                  : (eff_opc == OPC_PARAM_TABLE_READ_CMD) ? discoverable_param_table_byte
                  : array_rd_data;

  wire discoverable_param_table_end = (eff_opc == OPC_PARAM_TABLE_READ_CMD) &&
    (ptr[3:0] == 4'(DISCOVERABLE_PARAM_TABLE_BYTES - 1));
  wire [ADDR_BITS-1:0] ptr_inc = discoverable_param_table_end ? '0 : ptr + 1'b1;

  always_comb
  begin
    next_phase = eff_phase;
    next_cnt = cnt + 5'd1;
    next_ptr = ptr;
    unique case (eff_phase)
      ph_opc:
      if (last)
      begin
        next_cnt = 5'd0;
        if (op_has_addr)
          next_phase = ph_addr;
        else if (op_is_id)
          next_phase = id_phase_sel ? ph_ign : ph_dummy;
        else if (new_opc == OPC_SERIAL_NUMBER_READ_CMD)
          next_phase = ph_dout;
        else if (new_opc == OPC_SERIAL_NUMBER_WRITE_CMD)
          next_phase = ph_din;
        else
          next_phase = ph_ign;
        next_ptr = '0;
      end
      ph_addr:
      if (last)
      begin
        next_cnt = 5'd0;
        next_ptr = next_sh[ADDR_BITS-1:0];
        if (eff_opc == OPC_QIOR)
          next_phase = ph_mode;
        else if (eff_opc == OPC_READ)
          next_phase = ph_dout;
        else if (eff_opc inside {OPC_PP, OPC_QPP})
          next_phase = ph_din;
        else if (eff_opc inside {OPC_FAST, OPC_QOR, OPC_PARAM_TABLE_READ_CMD})
          next_phase = after_dummy_skip ? ph_dout : ph_dummy;
        else
          next_phase = ph_ign;
      end
      ph_mode:
      if (last)
      begin
        next_cnt = 5'd0;
        next_phase = after_dummy_skip ? ph_dout : ph_dummy;
      end
      ph_dummy:
      if (last)
      begin
        next_cnt = 5'd0;
        next_phase = ph_dout;
      end
      ph_dout:
      if (last)
      begin
        next_cnt = 5'd0;
        next_ptr = ptr_inc;
      end
      ph_din:
      if (last)
        next_cnt = 5'd0;
      ph_ign:
        next_cnt = cnt;
    endcase
  end

  // link state, restarted by every deselect
  always_ff @(posedge sck or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n || cs_n)
    begin
      fresh <= 1'b1;
      phase <= ph_opc;
      cnt <= 5'd0;
      sh <= 24'h000000;
      ptr <= '0;
    end
    else
    begin
      fresh <= 1'b0;
      phase <= next_phase;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
    end
  end

  wire din_byte = (eff_phase == ph_din) && last;
  wire [7:0] in_byte = next_sh[7:0];
  wire is_prog = eff_opc inside {OPC_PP, OPC_QPP};

  // link results survive deselect for the system domain
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opc_q <= 8'h00;
      addr_q <= '0;
      mode_cont <= 1'b0;
      nbytes <= 12'h000;
      partial <= 1'b0;
      sn_shift <= SN_RESET;
      done_tog <= 1'b0;
      prog_data <= 8'h00;
      prog_valid <= 1'b0;
      prog_index <= 11'h000;
    end
    else
    begin
      prog_valid <= 1'b0;
      if (fresh)
      begin
        nbytes <= 12'h000;
        partial <= 1'b0;
        mode_cont <= 1'b0;
      end
      if (fresh && f_cont)
      begin
        opc_q <= OPC_QIOR;
        done_tog <= ~done_tog;
      end
      if (eff_phase == ph_opc && last)
      begin
        opc_q <= new_opc;
        done_tog <= ~done_tog;
      end
      if (eff_phase == ph_addr && last)
        addr_q <= next_sh[ADDR_BITS-1:0];
      if (eff_phase == ph_mode && last)
        mode_cont <= (next_sh[7:4] == MODE_CONT);
      if (eff_phase == ph_din)
        partial <= !last;
      if (din_byte)
      begin
        if (nbytes != BYTE_COUNT_MAX)
          nbytes <= nbytes + 12'd1;
        sn_shift <= {in_byte, sn_shift[63:8]};
        // at most one page of data
        prog_valid <= is_prog && (nbytes < 12'(PAGE_BYTES));
        prog_data <= in_byte;
        prog_index <= nbytes[10:0];
      end
    end
  end

  // single lane output on lane one
  wire [2:0] bit_sel = 3'd7 - cnt[2:0];
  wire [3:0] nib = cnt[0] ? cur_byte[3:0] : cur_byte[7:4];
  wire [3:0] out_val = q_out ? nib : {2'b00, cur_byte[bit_sel], 1'b0};
  wire [3:0] oe_val = q_out ? 4'hF : 4'h2;

  // data changes on falling edges
  always_ff @(negedge sck or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n || cs_n)
    begin
      quad_data_lanes_out <= 4'h0;
      quad_data_lanes_oe <= 4'h0;
    end
    else if (eff_phase == ph_dout)
    begin
      quad_data_lanes_out <= out_val;
      quad_data_lanes_oe <= oe_val;
    end
    else
    begin
      quad_data_lanes_out <= 4'h0;
      quad_data_lanes_oe <= 4'h0;
    end
  end

  // system domain: deselect and command toggle synchronisers
  logic cs_s1;
  logic cs_s2;
  logic tg_s1;
  logic tg_s2;
  logic seen;
  logic armed;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
    end
    else
    begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      tg_s1 <= done_tog;
      tg_s2 <= tg_s1;
    end
  end

  // a command is acted on once chip select is seen high again
  wire commit = cs_s2 && (tg_s2 != seen);
  wire c_write_enable_cmd = (opc_q == OPC_WRITE_ENABLE_CMD);
  wire c_reset_arm_cmd = (opc_q == OPC_RESET_ARM_CMD);
  wire c_rst = (opc_q == OPC_RST);
  wire c_mbr = (opc_q == OPC_MBR);
  wire c_qior = (opc_q == OPC_QIOR);
  wire c_serial_number_write_cmd = (opc_q == OPC_SERIAL_NUMBER_WRITE_CMD);
  wire c_prog = opc_q inside {OPC_PP, OPC_QPP};
  wire c_scrub = opc_q inside {OPC_PSCRUB, OPC_CSCRUB};
  wire c_erase = opc_q inside {OPC_SE, OPC_BE, OPC_CE};
  wire may_start = commit && write_enable_latch && !op_req;
  wire go_prog = may_start && c_prog && (nbytes != 12'h000) && !partial &&
    !block_protect;
  wire go_scrub = may_start && c_scrub;
  wire go_erase = may_start && c_erase && !block_protect;
  wire start_op = go_prog || go_scrub || go_erase;
  wire short_page = nbytes < 12'(PAGE_BYTES);
  wire [3:0] first_kind = c_prog ? (short_page ? op_page_fill : op_page_erase)
    : (opc_q == OPC_PSCRUB) ? op_page_scrub
    : (opc_q == OPC_CSCRUB) ? op_chip_scrub
    : (opc_q == OPC_SE) ? op_sector_erase
    : (opc_q == OPC_BE) ? op_block_erase
    : op_chip_erase;
  wire [3:0] step_kind = (op_kind == op_page_fill) ? op_page_erase
    : op_page_prog;
  wire step_more = op_kind inside {op_page_fill, op_page_erase};
  wire op_finish = op_req && op_done && !step_more;
  wire do_rst = commit && c_rst && armed;
  wire sn_ok = commit && c_serial_number_write_cmd && write_enable_latch && !op_req &&
    (nbytes == 12'(SN_BYTES)) && !partial;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      seen <= 1'b0;
      armed <= 1'b0;
      write_enable_latch <= 1'b0;
      continuous_mode <= 1'b0;
      soft_reset <= 1'b0;
      serial_number <= SN_RESET;
    end
    else
    begin
      soft_reset <= do_rst;
      if (commit)
      begin
        seen <= tg_s2;
        armed <= c_reset_arm_cmd;
        if (c_qior)
          continuous_mode <= mode_cont;
        else if (c_mbr)
          continuous_mode <= 1'b0;
      end
      if (sn_ok)
        serial_number <= sn_shift;
      if (sn_ok || op_finish || do_rst)
        write_enable_latch <= 1'b0;
      if (do_rst)
        continuous_mode <= 1'b0;
      if (commit && c_write_enable_cmd)
        write_enable_latch <= 1'b1;
    end
  end

  // array operation sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      op_req <= 1'b0;
      op_kind <= op_none;
      op_addr <= '0;
      op_bytes <= 12'h000;
    end
    else if (start_op)
    begin
      op_req <= 1'b1;
      op_kind <= snr_op_t'(first_kind);
      op_addr <= addr_q;
      op_bytes <= nbytes;
    end
    else if (op_req && op_done)
    begin
      op_req <= step_more;
      op_kind <= step_more ? snr_op_t'(step_kind) : op_none;
    end
  end

  // configuration frozen while a frame is open
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      f_qpi <= 1'b0;
      f_quad <= 1'b0;
      f_lat <= 4'h0;
      f_busy <= 1'b0;
      f_cont <= 1'b0;
    end
    else if (cs_s2)
    begin
      f_qpi <= quad_command_mode;
      f_quad <= quad_enable;
      f_lat <= read_latency;
      f_busy <= op_req;
      f_cont <= continuous_mode;
    end
  end
endmodule

// ### core/snr_pkg.sv
// shared constants and types for the serial nor command interpreter
package snr_pkg;
  // address and table sizes
  localparam int ADDR_BITS = 24;
  localparam int ID_BYTES = 8;
  localparam int SN_BYTES = 8;
  localparam int DISCOVERABLE_PARAM_TABLE_BYTES = 16;
  localparam int PAGE_BYTES = 2048;
  localparam logic [11:0] BYTE_COUNT_MAX = 12'hFFF;
  // latency and edge counts per phase
  localparam int ID_DUMMY = 8;
  localparam int DISCOVERABLE_PARAM_TABLE_DUMMY = 8;
  localparam int CMD_EDGES_SINGLE = 8;
  localparam int CMD_EDGES_QUAD = 2;
  localparam int ADDR_EDGES_SINGLE = 24;
  localparam int ADDR_EDGES_QUAD = 6;
  localparam int MODE_EDGES = 2;
  localparam int BYTE_EDGES_SINGLE = 8;
  localparam int BYTE_EDGES_QUAD = 2;
  localparam logic [3:0] MODE_CONT = 4'hA;
  // opcodes
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST = 8'h0B;
  localparam logic [7:0] OPC_QOR = 8'h6B;
  localparam logic [7:0] OPC_QIOR = 8'hEB;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_QPP = 8'h32;
  localparam logic [7:0] OPC_PSCRUB = 8'hD3;
  localparam logic [7:0] OPC_CSCRUB = 8'hD4;
  localparam logic [7:0] OPC_SE = 8'h20;
  localparam logic [7:0] OPC_BE = 8'hD8;
  localparam logic [7:0] OPC_CE = 8'h60;
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] OPC_RST = 8'h99;
  localparam logic [7:0] OPC_MBR = 8'hFF;
  localparam logic [7:0] OPC_IDENT_READ_CMD = 8'h9F;
  localparam logic [7:0] OPC_QUAD_IDENT_READ_CMD = 8'hAF;
  localparam logic [7:0] OPC_SERIAL_NUMBER_READ_CMD = 8'hC3;
  localparam logic [7:0] OPC_SERIAL_NUMBER_WRITE_CMD = 8'hC2;
  localparam logic [7:0] OPC_PARAM_TABLE_READ_CMD = 8'h5A;
  // reset values
  localparam logic [63:0] SN_RESET = 64'h0000_0000_0000_0000;
  // link phases
  typedef enum logic [2:0] {
    ph_opc, ph_addr, ph_mode, ph_dummy, ph_dout, ph_din, ph_ign
  } snr_phase_t;
  // array operations handed to the back end
  typedef enum logic [3:0] {
    op_none, op_page_fill, op_page_erase, op_page_prog, op_page_scrub,
    op_chip_scrub, op_sector_erase, op_block_erase, op_chip_erase
  } snr_op_t;
endpackage

// ### sim/snr_chk.sv
// port assertions for the serial nor command interpreter
`timescale 1ns/1ps
module snr_chk
  import snr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic cs_n,
  input wire logic [3:0] quad_data_lanes_oe,
  // array operation
  input wire logic op_req,
  input wire snr_op_t op_kind,
  input wire logic [ADDR_BITS-1:0] op_addr,
  input wire logic op_done,
  // status
  input wire logic write_enable_latch,
  input wire logic continuous_mode,
  input wire logic soft_reset,
  input wire logic [63:0] serial_number
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_oe_idle: assert property (
    cs_n && $past(cs_n) |-> quad_data_lanes_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_req_hold: assert property (
    op_req && !op_done |=> op_req && $stable(op_kind) && $stable(op_addr))
    else $error("operation request dropped or changed");
  a_fill_next: assert property (
    op_req && op_done && op_kind == op_page_fill
    |=> op_req && op_kind == op_page_erase)
    else $error("page fill not followed by erase");
  a_erase_next: assert property (
    op_req && op_done && op_kind == op_page_erase
    |=> op_req && op_kind == op_page_prog)
    else $error("page erase not followed by program");
  a_req_latch: assert property (
    $rose(op_req) |-> write_enable_latch)
    else $error("operation started without latch");
  a_rst_pulse: assert property (
    soft_reset |=> !soft_reset)
    else $error("soft reset longer than one cycle");
  a_rst_clear: assert property (
    soft_reset |=> !write_enable_latch && !continuous_mode)
    else $error("soft reset left state set");
  a_sn_latch: assert property (
    !$stable(serial_number) |-> $past(write_enable_latch))
    else $error("serial number written without latch");
endmodule
bind snr_core snr_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .cs_n(cs_n), .quad_data_lanes_oe(quad_data_lanes_oe),
  .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr),
  .op_done(op_done), .write_enable_latch(write_enable_latch),
  .continuous_mode(continuous_mode), .soft_reset(soft_reset),
  .serial_number(serial_number));

// ### sim/snr_host.sv
// host controller model driving chip select, serial clock and lanes
`timescale 1ns/1ps
module snr_host (
  // serial link
  output logic sck,
  output logic cs_n,
  output logic [3:0] host_lanes,
  input wire logic [3:0] quad_data_lanes_out
);
  logic [3:0] rx;
  int half = 15;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    host_lanes = 4'h5;
  end
  task automatic cyc(input logic [3:0] v);
    host_lanes = v;
    #(half) sck = 1'b1;
    rx = quad_data_lanes_out;
    #(half) sck = 1'b0;
  endtask
  task automatic open_f();
    cs_n = 1'b0;
    #100;
  endtask
  task automatic close_f();
    #20 cs_n = 1'b1;
    host_lanes = ~host_lanes;
    #160;
  endtask
  task automatic tx8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      cyc({~host_lanes[3:1], b[i]});
  endtask
  task automatic tx24(input logic [23:0] a);
    tx8(a[23:16]);
    tx8(a[15:8]);
    tx8(a[7:0]);
  endtask
  task automatic rx8(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      cyc(~host_lanes);
      b[i] = rx[1];
    end
  endtask
  task automatic rxq(output logic [7:0] b);
    cyc(~host_lanes);
    b[7:4] = rx;
    cyc(~host_lanes);
    b[3:0] = rx;
  endtask
  task automatic cmd(input logic [7:0] op);
    open_f();
    tx8(op);
    close_f();
  endtask
endmodule

// ### sim/tb.sv
// self-checking testbench for the serial nor command interpreter
`timescale 1ns/1ps
module tb
  import snr_pkg::*;
;
  localparam logic [63:0] ID = 64'h8877_6655_4433_2211;
  localparam logic [127:0] SF = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;
  localparam logic [63:0] SN = 64'h1716_1514_1312_1110;
  logic ref_clk, rst_n, sck, cs_n;
  logic [3:0] host_lanes, quad_data_lanes_in, quad_data_lanes_out;
  logic [3:0] quad_data_lanes_oe, read_latency;
  logic quad_command_mode, quad_enable, block_protect;
  logic [23:0] array_rd_addr, op_addr;
  logic [7:0] array_rd_data, prog_data;
  logic prog_valid, op_req, op_done, write_enable_latch;
  logic continuous_mode, soft_reset;
  logic [10:0] prog_index;
  logic [11:0] op_bytes;
  logic [63:0] serial_number;
  snr_op_t op_kind;
  snr_op_t kinds[$];
  logic [7:0] pd[$];
  int miscompares = 0;
  int checked = 0;
  int dly = 20;
  int cnt = 0;
  int nrst = 0;
  snr_core #(.ID_VALUE(ID), .DISCOVERABLE_PARAM_TABLE_TABLE(SF)) u_dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .quad_data_lanes_in(quad_data_lanes_in),
    .quad_data_lanes_out(quad_data_lanes_out),
    .quad_data_lanes_oe(quad_data_lanes_oe),
    .quad_command_mode(quad_command_mode), .quad_enable(quad_enable),
    .read_latency(read_latency), .block_protect(block_protect),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
    .prog_data(prog_data), .prog_valid(prog_valid),
    .prog_index(prog_index), .op_req(op_req), .op_kind(op_kind),
    .op_addr(op_addr), .op_bytes(op_bytes), .op_done(op_done),
    .write_enable_latch(write_enable_latch),
    .continuous_mode(continuous_mode), .soft_reset(soft_reset),
    .serial_number(serial_number));
  snr_host h (.sck(sck), .cs_n(cs_n), .host_lanes(host_lanes),
    .quad_data_lanes_out(quad_data_lanes_out));
  assign quad_data_lanes_in = (quad_data_lanes_oe & quad_data_lanes_out) |
    (~quad_data_lanes_oe & host_lanes);
  assign array_rd_data = array_rd_addr[7:0] ^ 8'hA5;
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // back end answering array operations
  always @(posedge ref_clk)
  begin
    op_done <= 1'b0;
    if (soft_reset === 1'b1)
      nrst <= nrst + 1;
    if (op_req === 1'b1 && op_done !== 1'b1)
    begin
      cnt <= cnt + 1;
      if (cnt >= dly)
      begin
        op_done <= 1'b1;
        cnt <= 0;
        kinds.push_back(op_kind);
      end
    end
  end
  always @(negedge sck)
    if (prog_valid === 1'b1)
      pd.push_back(prog_data);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic idle();
    for (int i = 0; i < 2000 && op_req !== 1'b0; i++)
      @(posedge ref_clk);
    chk(op_req, 1'b0);
  endtask
  task automatic t_erase();
    logic [7:0] opc[5] = '{OPC_SE, OPC_BE, OPC_CE, OPC_PSCRUB, OPC_CSCRUB};
    snr_op_t k[5] = '{op_sector_erase, op_block_erase, op_chip_erase,
      op_page_scrub, op_chip_scrub};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk) block_protect <= (i > 2);
      h.cmd(OPC_WRITE_ENABLE_CMD);
      chk(write_enable_latch, 1'b1);
      h.open_f();
      h.tx8(opc[i]);
      if (i != 2 && i != 4)
        h.tx24(24'h012345);
      h.close_f();
      chk(op_kind, k[i]);
      idle();
      chk(write_enable_latch, 1'b0);
    end
    @(posedge ref_clk) block_protect <= 1'b0;
    h.cmd(OPC_CE);
    chk(op_req, 1'b0);
    @(posedge ref_clk) block_protect <= 1'b1;
    h.cmd(OPC_WRITE_ENABLE_CMD);
    h.cmd(OPC_CE);
    chk(op_req, 1'b0);
    @(posedge ref_clk) block_protect <= 1'b0;
  endtask
  task automatic t_prog();
    snr_op_t k[3] = '{op_page_fill, op_page_erase, op_page_prog};
    kinds.delete();
    pd.delete();
    h.cmd(OPC_WRITE_ENABLE_CMD);
    h.open_f();
    h.tx8(OPC_PP);
    h.tx24(24'h000800);
    h.tx8(8'hC3);
    h.tx8(8'h3C);
    h.close_f();
    chk(op_bytes, 12'h002);
    chk(op_addr, 24'h000800);
    idle();
    chk(pd.size(), 2);
    chk({pd[0], pd[1]}, 16'hC33C);
    chk(prog_index, 11'h001);
    chk(kinds.size(), 3);
    for (int i = 0; i < 3; i++)
      chk(kinds[i], k[i]);
  endtask
  task automatic t_read();
    logic [7:0] b;
    h.half = 17;
    h.open_f();
    h.tx8(OPC_READ);
    h.tx24(24'hFFFFFF);
    h.rx8(b);
    chk(b, 8'h5A);
    h.rx8(b);
    chk(b, 8'hA5);
    h.close_f();
    h.half = 15;
    @(posedge ref_clk) read_latency <= 4'h3;
    h.open_f();
    h.tx8(OPC_FAST);
    h.tx24(24'h000010);
    repeat (3) h.cyc(4'h0);
    h.rx8(b);
    chk(b, 8'hB5);
    h.close_f();
    h.open_f();
    h.tx8(OPC_QOR);
    h.tx24(24'h000020);
    repeat (3) h.cyc(4'h0);
    h.rxq(b);
    chk(b, 8'h85);
    h.close_f();
    h.open_f();
    h.tx8(OPC_QIOR);
    for (int i = 5; i >= 0; i--)
      h.cyc(i == 1 ? 4'h3 : 4'h0);
    h.cyc(4'hA);
    h.cyc(4'h0);
    repeat (3) h.cyc(4'h0);
    h.rxq(b);
    chk(b, 8'h95);
    h.close_f();
    chk(continuous_mode, 1'b1);
    h.open_f();
    repeat (8) h.cyc(4'hF);
    h.close_f();
    chk(continuous_mode, 1'b0);
    h.cmd(OPC_MBR);
    h.cmd(OPC_WRITE_ENABLE_CMD);
    chk(write_enable_latch, 1'b1);
  endtask
  task automatic t_id();
    logic [7:0] b;
    logic [3:0] oe;
    h.open_f();
    h.tx8(OPC_IDENT_READ_CMD);
    repeat (8) h.cyc(4'h0);
    for (int i = 0; i < 9; i++)
    begin
      h.rx8(b);
      chk(b, ID[8 * (i % 8) +: 8]);
    end
    h.close_f();
    chk(quad_data_lanes_oe, 4'h0);
    dly = 200;
    h.cmd(OPC_WRITE_ENABLE_CMD);
    h.cmd(OPC_CE);
    oe = 4'h0;
    h.open_f();
    h.tx8(OPC_IDENT_READ_CMD);
    repeat (24)
    begin
      h.cyc(4'h0);
      oe = oe | quad_data_lanes_oe;
    end
    h.close_f();
    chk(oe, 4'h0);
    chk(op_kind, op_chip_erase);
    idle();
    dly = 20;
    @(posedge ref_clk) quad_enable <= 1'b1;
    h.open_f();
    h.tx8(OPC_QUAD_IDENT_READ_CMD);
    repeat (8) h.cyc(4'h0);
    h.rxq(b);
    oe = quad_data_lanes_oe;
    h.close_f();
    chk(oe, 4'hF);
    chk(b, ID[7:0]);
    @(posedge ref_clk) quad_enable <= 1'b0;
    h.open_f();
    h.tx8(OPC_QUAD_IDENT_READ_CMD);
    repeat (12) h.cyc(4'h0);
    oe = quad_data_lanes_oe;
    h.close_f();
    chk(oe, 4'h0);
    @(posedge ref_clk) quad_command_mode <= 1'b1;
    h.open_f();
    h.cyc(OPC_QUAD_IDENT_READ_CMD[7:4]);
    h.cyc(OPC_QUAD_IDENT_READ_CMD[3:0]);
    repeat (8) h.cyc(4'h0);
    h.rxq(b);
    h.close_f();
    chk(b, ID[7:0]);
    @(posedge ref_clk) quad_command_mode <= 1'b0;
  endtask
  task automatic t_sn();
    logic [7:0] b;
    for (int n = 0; n < 3; n++)
    begin
      if (n > 0)
        h.cmd(OPC_WRITE_ENABLE_CMD);
      h.open_f();
      h.tx8(OPC_SERIAL_NUMBER_WRITE_CMD);
      for (int i = 0; i < 8 - n / 2; i++)
        h.tx8(8'h10 + i[7:0] + (n == 2 ? 8'h40 : 8'h00));
      h.close_f();
      chk(serial_number, n == 0 ? 64'h0 : SN);
      if (n == 1)
        chk(write_enable_latch, 1'b0);
    end
    h.open_f();
    h.tx8(OPC_SERIAL_NUMBER_READ_CMD);
    for (int i = 0; i < 9; i++)
    begin
      h.rx8(b);
      chk(b, SN[8 * (i % 8) +: 8]);
    end
    h.close_f();
  endtask
  task automatic t_discoverable_param_table();
    logic [7:0] b;
    h.open_f();
    h.tx8(OPC_PARAM_TABLE_READ_CMD);
    h.tx24(24'h00000F);
    repeat (8) h.cyc(4'h0);
    h.rx8(b);
    chk(b, SF[127:120]);
    h.rx8(b);
    chk(b, SF[7:0]);
    h.close_f();
  endtask
  task automatic t_rst();
    h.cmd(OPC_RESET_ARM_CMD);
    h.cmd(OPC_WRITE_ENABLE_CMD);
    h.cmd(OPC_RST);
    chk(nrst, 0);
    chk(write_enable_latch, 1'b1);
    h.cmd(OPC_RESET_ARM_CMD);
    h.cmd(OPC_RST);
    chk(nrst, 1);
    chk(write_enable_latch, 1'b0);
    h.cmd(OPC_RST);
    chk(nrst, 1);
  endtask
  initial
  begin
    rst_n <= 1'b0;
    block_protect <= 1'b0;
    quad_enable <= 1'b0;
    quad_command_mode <= 1'b0;
    read_latency <= 4'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_erase();
    t_prog();
    t_read();
    t_id();
    t_sn();
    t_discoverable_param_table();
    t_rst();
    end_of_test();
  end
  initial
  begin
    #1000000;
    miscompares++;
    end_of_test();
  end
endmodule
